//--- i2cm_consts.vh
// constants for the single-master two-wire serial engine
// assumes inclusion by i2cm_top.v only; the sda delay counts are in clk cycles
`ifndef I2CM_CONSTS_VH
`define I2CM_CONSTS_VH
// ten bits so a fast clock still divides down to standard-mode rates
`define I2CM_DIV_W          10
`define I2CM_DIV_RESET      8'h20
`define I2CM_FILT_W         2
`define I2CM_SYNC_EXTRA     1
`define I2CM_SDA_DLY_SHORT  3'h2
`define I2CM_SDA_DLY_LONG   3'h7
`define I2CM_BITS_PER_BYTE  4'h9
`define I2CM_ADDR_RW_BIT    0
`define I2CM_FIFO_DEPTH     8
`define I2CM_FIFO_AW        3
`endif

//--- i2cm_fifo.v
// small flip-flop fifo with valid/ready handshakes on both sides
// assumes one clock and an asynchronous active-low reset
module i2cm_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    rd_ptr_reg;
    reg [AW:0]      count_reg;
    wire            push = in_valid && in_ready;
    wire            pop  = out_valid && out_ready;
    reg             in_ready_reg;  // registered so the port comes from a flop
    integer         i;

    assign in_ready  = in_ready_reg;
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data  = mem_reg[rd_ptr_reg];

    // pointer and occupancy bookkeeping
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
            in_ready_reg <= 1'b1;
            for (i = 0; i < DEPTH; i = i + 1)
                mem_reg[i] <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                mem_reg[wr_ptr_reg] <= in_data;
                wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                                   : wr_ptr_reg + 1'b1;
            end
            if (pop)
                rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                                   : rd_ptr_reg + 1'b1;
            if (push && !pop) begin
                count_reg    <= count_reg + 1'b1;
                in_ready_reg <= (count_reg != DEPTH[AW:0] - 1'b1); // last slot taken
            end else if (pop && !push) begin
                count_reg    <= count_reg - 1'b1;
                in_ready_reg <= 1'b1;
            end
        end
    end
endmodule

//--- i2cm_top.v
// single-master two-wire engine: start, byte shift with ack, stop
// assumes external pull-ups on both lines; the host keeps the transfer protocol
`include "i2cm_consts.vh"
module i2cm_top #(
    parameter DIV_W = `I2CM_DIV_W
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire [DIV_W-1:0] baud_divider,
    input  wire             sync_enable,
    input  wire             sda_long_delay,
    input  wire             tx_irq_on_empty,
    input  wire             cmd_start,
    input  wire             cmd_stop,
    input  wire             ack_to_send,
    input  wire [7:0]       tx_data,
    input  wire             tx_valid,
    output wire             tx_ready,
    output reg  [7:0]       rx_data,
    output reg              rx_valid,
    output reg              ack_received,
    output reg              tx_shift_empty_flag,
    output reg              start_stop_event,
    output reg              byte_event,
    output reg              busy,
    input  wire             serial_clock_line_ch_in,
    output reg              serial_clock_line_ch_out,
    output reg              serial_clock_line_ch_oe,
    input  wire             serial_data_line_ch_in,
    output reg              serial_data_line_ch_out,
    output reg              serial_data_line_ch_oe
);
    localparam ST_IDLE = 3'h0, ST_START = 3'h1, ST_LOW = 3'h2, ST_HIGH = 3'h3,
               ST_STOP1 = 3'h4, ST_STOP2 = 3'h5;

    //////////////////////////////////////////////////////////////////////////
    // tx fifo: host loads bytes ahead, engine pops one per address or write byte, none per read byte
    wire [7:0] fifo_data;
    wire       fifo_valid;
    reg        fifo_pop;
    i2cm_fifo #(.WIDTH(8), .DEPTH(`I2CM_FIFO_DEPTH), .AW(`I2CM_FIFO_AW)) u_fifo (
        .clk      (clk),
        .rst_n    (rst_n),
        .in_data  (tx_data),
        .in_valid (tx_valid),
        .in_ready (tx_ready),
        .out_data (fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    //////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers, then a noise filter on scl
    reg [1:0] scl_sync_reg;
    reg [1:0] sda_sync_reg;
    reg [`I2CM_FILT_W:0] scl_filt_reg;
    reg       scl_hi_reg;
    reg       sda_prev_reg;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_filt_reg <= {(`I2CM_FILT_W+1){1'b1}};
            scl_hi_reg   <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], serial_clock_line_ch_in};
            sda_sync_reg <= {sda_sync_reg[0], serial_data_line_ch_in};
            scl_filt_reg <= {scl_filt_reg[`I2CM_FILT_W-1:0], scl_sync_reg[1]};
            // level accepted once stable across the filter width
            if (&scl_filt_reg)
                scl_hi_reg <= 1'b1;
            else if (~|scl_filt_reg)
                scl_hi_reg <= 1'b0;
            sda_prev_reg <= sda_sync_reg[1];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // engine state
    reg [2:0]       state_reg;
    reg [DIV_W-1:0] cnt_reg;       // half-period counter
    reg [3:0]       bit_reg;       // 1..9 within byte
    reg [7:0]       shift_reg;
    reg             reading_reg;   // direction of data bytes after address
    reg             first_reg;     // current byte is the address byte
    reg             sda_want_reg;  // sda level wanted after delay
    reg [2:0]       dly_reg;
    wire [2:0]      dly_set = sda_long_delay ? `I2CM_SDA_DLY_LONG : `I2CM_SDA_DLY_SHORT;
    wire            half_done = (cnt_reg == baud_divider); // divider+1 ticks
    // bus stop seen: sda rising while scl high; both lines equally delayed,
    // else a slave moving sda right after the scl fall looks like a stop
    wire            stop_seen = scl_sync_reg[1] && sda_sync_reg[1] && !sda_prev_reg;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= {DIV_W{1'b0}};
            bit_reg   <= 4'h0;
            shift_reg <= 8'hFF;
            reading_reg <= 1'b0;
            first_reg <= 1'b0;
            sda_want_reg <= 1'b1;
            dly_reg   <= 3'h0;
            fifo_pop  <= 1'b0;
            rx_data   <= 8'h00;
            rx_valid  <= 1'b0;
            ack_received <= 1'b1;
            tx_shift_empty_flag <= 1'b1;
            start_stop_event <= 1'b0;
            byte_event <= 1'b0;
            busy <= 1'b0;
            serial_clock_line_ch_out <= 1'b0;
            serial_clock_line_ch_oe  <= 1'b0;
            serial_data_line_ch_out  <= 1'b0;
            serial_data_line_ch_oe   <= 1'b0;
        end else begin
            fifo_pop <= 1'b0;
            rx_valid <= 1'b0;
            byte_event <= 1'b0;
            start_stop_event <= stop_seen && busy;
            // delayed sda output; open drain only drives low
            if (sda_want_reg == !serial_data_line_ch_oe)
                dly_reg <= 3'h0;
            else if (dly_reg == dly_set)
                serial_data_line_ch_oe <= !sda_want_reg;
            else
                dly_reg <= dly_reg + 3'h1;
            case (state_reg)
            ST_IDLE: begin
                serial_clock_line_ch_oe <= 1'b0;
                if (stop_seen)
                    busy <= 1'b0;
                if (cmd_start && scl_hi_reg) begin
                    sda_want_reg <= 1'b0;     // start: sda falls while scl high
                    cnt_reg <= {DIV_W{1'b0}};
                    busy <= 1'b1;
                    state_reg <= ST_START;
                end
            end
            ST_START: begin
                if (!serial_data_line_ch_oe)
                    cnt_reg <= {DIV_W{1'b0}};
                else if (half_done) begin
                    serial_clock_line_ch_oe <= 1'b1;
                    start_stop_event <= 1'b1;
                    first_reg <= 1'b1;
                    bit_reg <= 4'h0;
                    cnt_reg <= {DIV_W{1'b0}};
                    state_reg <= ST_LOW;
                end else
                    cnt_reg <= cnt_reg + 1'b1;
            end
            ST_LOW: begin
                if (bit_reg == 4'h0) begin
                    // wait for a byte; stop allowed while idle between bytes
                    if (cmd_stop) begin
                        sda_want_reg <= 1'b0;
                        state_reg <= ST_STOP1;
                    end else if (fifo_valid || (reading_reg && !first_reg)) begin
                        shift_reg <= (reading_reg && !first_reg) ? 8'hFF : fifo_data;
                        if (fifo_valid && !(reading_reg && !first_reg))
                            fifo_pop <= 1'b1;
                        if (first_reg)
                            reading_reg <= fifo_data[`I2CM_ADDR_RW_BIT];
                        tx_shift_empty_flag <= 1'b0;
                        bit_reg <= 4'h1;
                        cnt_reg <= {DIV_W{1'b0}};
                    end
                end else if (half_done) begin
                    serial_clock_line_ch_oe <= 1'b0;
                    cnt_reg <= {DIV_W{1'b0}};
                    state_reg <= ST_HIGH;
                end else begin
                    cnt_reg <= cnt_reg + 1'b1;
                    // data set early in low phase, msb first
                    if (bit_reg == `I2CM_BITS_PER_BYTE)
                        sda_want_reg <= (reading_reg && !first_reg) ? ack_to_send : 1'b1;
                    else
                        sda_want_reg <= shift_reg[7];
                end
            end
            ST_HIGH: begin
                // with sync_enable set, high phase counted only once line reads high
                if (sync_enable && !scl_hi_reg)
                    cnt_reg <= {DIV_W{1'b0}};
                else if (half_done) begin
                    serial_clock_line_ch_oe <= 1'b1;  // falling edge
                    cnt_reg <= {DIV_W{1'b0}};
                    state_reg <= ST_LOW;
                    if (bit_reg == `I2CM_BITS_PER_BYTE) begin
                        bit_reg <= 4'h0;
                        first_reg <= 1'b0;
                        tx_shift_empty_flag <= 1'b1;
                        if (tx_irq_on_empty)
                            byte_event <= 1'b1;
                        if (reading_reg && !first_reg) begin
                            rx_data <= shift_reg;
                            rx_valid <= 1'b1;
                        end
                    end else
                        bit_reg <= bit_reg + 4'h1;
                end else begin
                    cnt_reg <= cnt_reg + 1'b1;
                    // sample mid-high phase
                    if (cnt_reg == {1'b0, baud_divider[DIV_W-1:1]}) begin
                        if (bit_reg == `I2CM_BITS_PER_BYTE)
                            ack_received <= sda_sync_reg[1];
                        else
                            shift_reg <= {shift_reg[6:0], sda_sync_reg[1]};
                    end
                end
            end
            ST_STOP1: begin
                // hold sda low, then release scl
                if (serial_data_line_ch_oe && half_done) begin
                    serial_clock_line_ch_oe <= 1'b0;
                    cnt_reg <= {DIV_W{1'b0}};
                    state_reg <= ST_STOP2;
                end else if (!half_done)
                    cnt_reg <= cnt_reg + 1'b1; // hold at the end for a slow sda
            end
            ST_STOP2: begin
                if (scl_hi_reg && half_done) begin
                    sda_want_reg <= 1'b1;     // stop: sda rises while scl high
                    reading_reg <= 1'b0;
                    state_reg <= ST_IDLE;     // busy drops when stop seen
                end else if (scl_hi_reg)
                    cnt_reg <= cnt_reg + 1'b1;
            end
            default: state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule

//--- i2cm_checker.sv
// assertions on the ports of the two-wire serial engine
// assumes a bind onto i2cm_top; one clock, async active-low reset
module i2cm_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sda_long_delay,
    input wire logic tx_irq_on_empty,
    input wire logic ack_received,
    input wire logic start_stop_event,
    input wire logic byte_event,
    input wire logic busy,
    input wire logic serial_clock_line_ch_out,
    input wire logic serial_clock_line_ch_oe,
    input wire logic serial_data_line_ch_out,
    input wire logic serial_data_line_ch_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] fall_cnt_reg;
    logic       scl_oe_d_reg;
    logic       bit9;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    // scl releases per transfer; nine per byte, so a ninth bit is a multiple
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fall_cnt_reg <= 8'h00;
            scl_oe_d_reg <= 1'b0;
        end else begin
            scl_oe_d_reg <= serial_clock_line_ch_oe;
            if (!busy)
                fall_cnt_reg <= 8'h00;
            else if (scl_oe_d_reg && !serial_clock_line_ch_oe)
                fall_cnt_reg <= fall_cnt_reg + 8'h01;
        end
    end
    assign bit9 = (fall_cnt_reg != 8'h00) && (fall_cnt_reg % 9 == 0);
    ////////////////////////////////////////
    property p_open_drain; !serial_clock_line_ch_out && !serial_data_line_ch_out; endproperty
    a_open_drain: assert property (p_open_drain) else $error("line driven high");
    property p_start_done; $rose(busy) |-> ##[0:600] start_stop_event; endproperty
    a_start_done: assert property (p_start_done) else $error("no start event");
    property p_stop_seen; $fell(busy) |-> start_stop_event || $past(start_stop_event); endproperty
    a_stop_seen: assert property (p_stop_seen) else $error("no stop event");
    property p_ss_pulse; start_stop_event |=> !start_stop_event; endproperty
    a_ss_pulse: assert property (p_ss_pulse) else $error("start/stop event too long");
    property p_byte_ninth; byte_event |-> bit9 && serial_clock_line_ch_oe; endproperty
    a_byte_ninth: assert property (p_byte_ninth) else $error("byte event off ninth fall");
    property p_byte_src; byte_event |-> tx_irq_on_empty ##1 !byte_event; endproperty
    a_byte_src: assert property (p_byte_src) else $error("byte event source wrong");
    property p_ack_sample; $changed(ack_received) |-> bit9 && !serial_clock_line_ch_oe; endproperty
    a_ack_sample: assert property (p_ack_sample) else $error("ack taken off bit nine");
    property p_sda_short;
        $rose(serial_clock_line_ch_oe) && busy |=> $stable(serial_data_line_ch_oe);
    endproperty
    a_sda_short: assert property (p_sda_short) else $error("sda moved too soon");
    property p_sda_long;
        $rose(serial_clock_line_ch_oe) && busy && sda_long_delay
            |=> $stable(serial_data_line_ch_oe) [*6];
    endproperty
    a_sda_long: assert property (p_sda_long) else $error("long sda delay short");
endmodule
bind i2cm_top i2cm_checker i2cm_checker_inst (.clk, .rst_n, .sda_long_delay,
    .tx_irq_on_empty, .ack_received, .start_stop_event, .byte_event, .busy,
    .serial_clock_line_ch_out, .serial_clock_line_ch_oe, .serial_data_line_ch_out,
    .serial_data_line_ch_oe);

//--- i2cm_slave_model.sv
// behavioural addressed slave on the open-drain two-wire bus
// assumes pull-ups resolved by the bench; acks its address unless told to refuse
module i2cm_slave_model (
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic [31:0] stretch_ns,
    input  wire logic nack_addr,
    output logic      scl_oe,
    output logic      sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got_q[$];
    logic [7:0] rd_q[$];
    logic [7:0] sh;
    logic [7:0] cur;
    logic       rd;
    logic       first;
    logic       nack;
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end
    // slow answer: hold scl low after each fall
    always @(negedge scl) if (stretch_ns > 0) begin
        scl_oe = 1'b1;
        #(stretch_ns) scl_oe = 1'b0;
    end
    // a stop ends the frame and frees the data line
    always @(posedge sda) if (scl === 1'b1) begin
        disable frame;
        sda_oe = 1'b0;
    end
    // byte engine; stops driving after a nack so the master can stop
    always begin : frame
        @(negedge sda iff scl === 1'b1);
        first = 1'b1;
        rd = 1'b0;
        nack = 1'b0;
        @(negedge scl);
        forever begin
            cur = (rd && rd_q.size() > 0) ? rd_q.pop_front() : 8'hFF;
            for (int i = 7; i >= 0; i--) begin
                sda_oe = rd && !nack && !cur[i];
                @(posedge scl);
                sh[i] = sda;
                @(negedge scl);
            end
            sda_oe = !rd && !(first && nack_addr);
            if (!rd) got_q.push_back(sh);
            if (first && !nack_addr) rd = sh[0];
            first = 1'b0;
            @(posedge scl);
            nack = sda;
            @(negedge scl);
        end
    end
endmodule

//--- i2cm_top_test.sv
// self-checking bench: host stimulus, slave model, reference queues
// assumes the checker binds itself onto i2cm_top
module i2cm_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 0, rst_n = 0, sync_enable = 0, sda_long_delay = 0;
    logic       tx_irq_on_empty = 1, cmd_start = 0, cmd_stop = 0, ack_to_send = 0;
    logic [9:0] baud_divider = 10'h004;
    logic [7:0] tx_data = 8'h00, rx_data;
    logic       s_nack = 0;
    logic       tx_valid = 0, tx_ready, rx_valid, ack_received, tx_shift_empty_flag;
    logic       start_stop_event, byte_event, busy, scl_oe, sda_oe, s_scl_oe, s_sda_oe;
    wire        scl, sda;
    int         num_errors = 0, n_checks = 0, stretch = 0;
    logic [31:0] seed = 32'h000164EE;
    logic [7:0] exp_q[$];
    always #4 clk = ~clk;
    // open-drain lines with pull-ups
    assign scl = !(scl_oe || s_scl_oe);
    assign sda = !(sda_oe || s_sda_oe);
    i2cm_top i2cm_top_inst (.clk, .rst_n, .baud_divider, .sync_enable, .sda_long_delay,
        .tx_irq_on_empty, .cmd_start, .cmd_stop, .ack_to_send, .tx_data, .tx_valid,
        .tx_ready, .rx_data, .rx_valid, .ack_received, .tx_shift_empty_flag,
        .start_stop_event, .byte_event, .busy, .serial_clock_line_ch_in(scl),
        .serial_clock_line_ch_out(), .serial_clock_line_ch_oe(scl_oe),
        .serial_data_line_ch_in(sda), .serial_data_line_ch_out(),
        .serial_data_line_ch_oe(sda_oe));
    i2cm_slave_model i2cm_slave_model_inst (.scl(scl), .sda(sda), .stretch_ns(stretch),
        .nack_addr(s_nack), .scl_oe(s_scl_oe), .sda_oe(s_sda_oe));
    ////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic tick(); @(posedge clk); #1; endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // a wait that runs out is a mismatch and ends the run
    task automatic give_up(input string nm);
        chk(nm, 1, 0);
        conclude();
    endtask
    // bounded wait for a one-cycle event
    task automatic wait_ev(input bit byte_ev);
        for (int i = 0; i < 20000; i++) begin
            tick();
            if ((byte_ev ? byte_event : start_stop_event) === 1'b1) return;
        end
        num_errors++;
        $display("MISMATCH timeout waiting for event");
        conclude();
    endtask
    // hold data and valid until the edge that sees ready
    task automatic push(input logic [7:0] d);
        tx_data = d;
        tx_valid = 1;
        for (int i = 0; i < 20000 && tx_ready !== 1'b1; i++) tick();
        if (tx_ready !== 1'b1) give_up("tx_ready wait");
        tick();
    endtask
    // one scl period measured from the master's own drive
    task automatic rate();
        int n;
        for (int i = 0; i < 3000 && scl_oe !== 1'b0; i++) tick();
        for (int i = 0; i < 3000 && scl_oe !== 1'b1; i++) tick();
        for (n = 0; n < 3000 && scl_oe !== 1'b0; n++) tick();
        for (int i = 0; i < 3000 && scl_oe !== 1'b1; i++) begin tick(); n++; end
        if (scl_oe !== 1'b1 || n >= 3000) give_up("scl period wait");
        if (sync_enable) chk("slowed period", 1, n > 2 * (baud_divider + 1));
        else chk("period", 2 * (baud_divider + 1), n);
    endtask
    task automatic xfer(input bit rd, input int nb, input bit na);
        logic [31:0] r;
        s_nack = na;
        r = xs();
        exp_q = {{r[7:1], rd}};
        for (int k = 0; k < nb; k++) begin r = xs(); exp_q.push_back(r[7:0]); end
        if (rd) i2cm_slave_model_inst.rd_q = exp_q[1:$];
        cmd_start = 1;
        tick();
        cmd_start = 0;
        wait_ev(0);
        if (rd) push(exp_q[0]);
        else foreach (exp_q[k]) push(exp_q[k]);
        chk("tx_ready", rd, tx_ready);
        tx_valid = 0;
        rate();
        for (int k = 0; k <= nb; k++) begin
            ack_to_send = (k == nb);
            wait_ev(1);
            chk("ack", (rd && k == nb) || na, ack_received);
            chk("shift empty", 1, tx_shift_empty_flag);
            chk("rx_valid", rd && k > 0, rx_valid);
            if (rd && k > 0) chk("rx_data", exp_q[k], rx_data);
            if (na) break;
        end
        cmd_stop = 1;
        wait_ev(0);
        cmd_stop = 0;
        tick();
        chk("busy", 0, busy);
        chk("bytes", rd ? 1 : nb + 1, i2cm_slave_model_inst.got_q.size());
        foreach (i2cm_slave_model_inst.got_q[k])
            chk("wire byte", exp_q[k], i2cm_slave_model_inst.got_q[k]);
        i2cm_slave_model_inst.got_q = {};
        s_nack = 0;
    endtask
    ////////////////////////////////////////
    initial begin
        logic [31:0] r;
        repeat (8) @(posedge clk);
        #1 rst_n = 1;
        repeat (8) tick();
        r = xs();
        // low half kept longer than the long sda delay
        baud_divider = 10'h00A + {8'h00, r[1:0]};
        // write filling the fifo, prompt slave
        xfer(0, 8, 0);
        // read with sync, long sda delay and a stretching slave
        sync_enable = 1;
        sda_long_delay = 1;
        stretch = 200;
        xfer(1, 3, 0);
        // address refused: host stops at once
        xfer(1, 1, 1);
        conclude();
    end
endmodule
